// ==== pkg/pio_pkg.sv ====
package pio_pkg;
   localparam int          PIO_PINS_MAX    = 29;
   localparam int          PIO_PORTS       = 4;
   localparam int          PIO_DBG_PIN     = 24;
   localparam logic [11:0] PIO_ADR_LATCH   = 12'h000;
   localparam logic [11:0] PIO_ADR_INMODE  = 12'h010;
   localparam logic [11:0] PIO_ADR_OUTMODE = 12'h020;
   localparam logic [11:0] PIO_ADR_SKIP    = 12'h030;
   localparam logic [11:0] PIO_ADR_CTRL    = 12'h040;
   localparam logic [11:0] PIO_ADR_PINS    = 12'h050;
   localparam int          PIO_CTRL_XBE    = 0;
   localparam int          PIO_CTRL_WPD    = 1;
   localparam logic [7:0]  PIO_LATCH_RST   = 8'hFF;
   localparam logic [7:0]  PIO_MODE_RST    = 8'h00;
endpackage

// ==== core/pio_cell.sv ====
`timescale 1ns/1ps
module pio_cell (
   input  wire logic analog_en,
   input  wire logic push_pull,
   input  wire logic out_val,
   input  wire logic active,
   input  wire logic wpu_dis,
   input  wire logic pad_sync,
   output logic      pad_o,
   output logic      pad_oe_n,
   output logic      pullup_en,
   output logic      rd_val
);
   logic drive;
   always_comb begin
      drive    = active && !analog_en && (push_pull || !out_val);
      pad_o    = out_val;
      pad_oe_n = !drive;
      pullup_en = !analog_en && !wpu_dis && !(drive && !out_val);
      rd_val    = analog_en ? 1'b0 : pad_sync;
   end
endmodule

// ==== core/pio_top.sv ====
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module pio_top
   import pio_pkg::*;
#(
   parameter int NPINS = PIO_PINS_MAX
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [NPINS-1:0] periph_out,
   input  wire logic [NPINS-1:0] periph_claim,
   input  wire logic             dbg_active,
   input  wire logic             dbg_out,
   input  wire logic             dbg_oe,
   output logic                  dbg_in,
   output logic [NPINS-1:0]      crossbar_skip,
   output logic [NPINS-1:0]      analog_sel,
   output logic [NPINS-1:0]      pin_level,
   input  wire logic [NPINS-1:0] pad_i,
   output logic [NPINS-1:0]      pad_o,
   output logic [NPINS-1:0]      pad_oe_n,
   output logic [NPINS-1:0]      pad_pullup_en
);
   localparam int W = PIO_PORTS * 8;
   logic [W-1:0]     latch_q, latch_d, inmode_q, inmode_d, outmode_q, outmode_d;
   logic [W-1:0]     skip_q, skip_d;
   logic             xbe_q, xbe_d, wpd_q, wpd_d;
   logic [31:0]      prdata_q, prdata_d;
   logic             pready_q, pready_d, pslverr_q, pslverr_d;
   logic [NPINS-1:0] sync1_q, sync2_q;
   logic [NPINS-1:0] po_d, poe_d, pu_d, rd_d, po_q, poe_q, pu_q, rd_q;
   logic [NPINS-1:0] ov, act, pp;
   logic             dbg_in_q;
   logic [W-1:0]     rd_ext;
   logic [1:0]       port;
   logic [3:0]       grp;
   logic             hit;

   always_comb begin
      rd_ext              = '0;
      rd_ext[NPINS-1:0]   = rd_q;
      port                = paddr[3:2];
      grp                 = paddr[7:4];
      latch_d             = latch_q;
      inmode_d            = inmode_q;
      outmode_d           = outmode_q;
      skip_d              = skip_q;
      xbe_d               = xbe_q;
      wpd_d               = wpd_q;
      prdata_d            = prdata_q;
      pslverr_d           = 1'b0;
      pready_d            = psel && !penable;
      hit                 = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00);
      if (psel && !penable) begin
         prdata_d = '0;
         unique case ({hit, grp})
            {1'b1, PIO_ADR_LATCH[7:4]}: begin
               if (pwrite) latch_d[port*8 +: 8] = pwdata[7:0];
               else prdata_d[7:0] = rd_ext[port*8 +: 8];
            end
            {1'b1, PIO_ADR_INMODE[7:4]}: begin
               if (pwrite) inmode_d[port*8 +: 8] = pwdata[7:0];
               else prdata_d[7:0] = inmode_q[port*8 +: 8];
            end
            {1'b1, PIO_ADR_OUTMODE[7:4]}: begin
               if (pwrite) outmode_d[port*8 +: 8] = pwdata[7:0];
               else prdata_d[7:0] = outmode_q[port*8 +: 8];
            end
            {1'b1, PIO_ADR_SKIP[7:4]}: begin
               if (pwrite) skip_d[port*8 +: 8] = pwdata[7:0];
               else prdata_d[7:0] = skip_q[port*8 +: 8];
            end
            {1'b1, PIO_ADR_CTRL[7:4]}: begin
               if (port != 2'd0) pslverr_d = 1'b1;
               else if (pwrite) begin
                  xbe_d = pwdata[PIO_CTRL_XBE];
                  wpd_d = pwdata[PIO_CTRL_WPD];
               end else begin
                  prdata_d[PIO_CTRL_XBE] = xbe_q;
                  prdata_d[PIO_CTRL_WPD] = wpd_q;
               end
            end
            default: pslverr_d = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q   <= {PIO_PORTS{PIO_LATCH_RST}};
         inmode_q  <= {PIO_PORTS{PIO_MODE_RST}};
         outmode_q <= {PIO_PORTS{PIO_MODE_RST}};
         skip_q    <= {PIO_PORTS{PIO_MODE_RST}};
         xbe_q     <= 1'b0;
         wpd_q     <= 1'b0;
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         latch_q   <= latch_d;
         inmode_q  <= inmode_d;
         outmode_q <= outmode_d;
         skip_q    <= skip_d;
         xbe_q     <= xbe_d;
         wpd_q     <= wpd_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // pads come from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pad_i;
         sync2_q <= sync1_q;
      end
   end

   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         // skipped pins are never handed to a peripheral
         ov[i]  = (periph_claim[i] && !skip_q[i]) ? periph_out[i] : latch_q[i];
         act[i] = xbe_q;
         pp[i]  = outmode_q[i];
      end
      if (NPINS > PIO_DBG_PIN && dbg_active) begin
         // debug owns the shared pin while active, overriding latch, crossbar, XBE and output mode but not analog input mode
         ov[PIO_DBG_PIN]  = dbg_out;
         act[PIO_DBG_PIN] = dbg_oe;
         pp[PIO_DBG_PIN]  = 1'b1;
      end
   end

   for (genvar g = 0; g < NPINS; g++) begin : g_cell
      pio_cell u_cell (
         .analog_en (inmode_q[g]),
         .push_pull (pp[g]),
         .out_val   (ov[g]),
         .active    (act[g]),
         .wpu_dis   (wpd_q && xbe_q),
         .pad_sync  (sync2_q[g]),
         .pad_o     (po_d[g]),
         .pad_oe_n  (poe_d[g]),
         .pullup_en (pu_d[g]),
         .rd_val    (rd_d[g])
      );
   end

   // registered pad controls add one cycle of output latency but keep outputs glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         po_q     <= '1;
         poe_q    <= '1;
         pu_q     <= '1;
         rd_q     <= '0;
         dbg_in_q <= 1'b0;
      end else begin
         po_q     <= po_d;
         poe_q    <= poe_d;
         pu_q     <= pu_d;
         rd_q     <= rd_d;
         dbg_in_q <= (NPINS > PIO_DBG_PIN) ? sync2_q[PIO_DBG_PIN % NPINS] : 1'b0;
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign pad_o         = po_q;
   assign pad_oe_n      = poe_q;
   assign pad_pullup_en = pu_q;
   assign pin_level     = rd_q;
   assign dbg_in        = dbg_in_q;
   assign crossbar_skip = skip_q[NPINS-1:0];
   assign analog_sel    = inmode_q[NPINS-1:0];
endmodule

// ==== verification/pio_pad_model.sv ====
`timescale 1ns/1ps
module pio_pad_model #(
   parameter int N = 29
) (
   input  wire logic [N-1:0] pad_o,
   input  wire logic [N-1:0] pad_oe_n,
   input  wire logic [N-1:0] pad_pullup_en,
   input  wire logic [N-1:0] ext_en,
   input  wire logic [N-1:0] ext_v,
   input  wire logic         pclk,
   output logic [N-1:0]      pad_i
);
   logic tog_q = 1'b0;
   // a floating pad flips each cycle so a lost pull-up never reads clean
   always @(posedge pclk) tog_q <= ~tog_q;
   assign pad_i = (~pad_oe_n & pad_o) | (pad_oe_n & ((ext_en & ext_v)
                  | (~ext_en & (pad_pullup_en | {N{tog_q}}))));
endmodule

// ==== verification/pio_top_checker.sv ====
`timescale 1ns/1ps
module pio_top_checker #(
   parameter int NPINS = 29
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic [NPINS-1:0] analog_sel,
   input wire logic [NPINS-1:0] pin_level,
   input wire logic [NPINS-1:0] pad_i,
   input wire logic [NPINS-1:0] pad_o,
   input wire logic [NPINS-1:0] pad_oe_n,
   input wire logic [NPINS-1:0] pad_pullup_en
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready && penable; endproperty
   a_rdy: assert property (p_rdy) else $error("no pready");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long pready");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
   property p_rst; $rose(presetn) |-> &pad_oe_n && &pad_pullup_en; endproperty
   a_rst: assert property (p_rst) else $error("pads not idle");
   property p_ana;
      $stable(analog_sel) |-> !(analog_sel & (~pad_oe_n | pad_pullup_en));
   endproperty
   a_ana: assert property (p_ana) else $error("analog pin active");
   property p_low; !(~pad_oe_n & ~pad_o & pad_pullup_en); endproperty
   a_low: assert property (p_low) else $error("pull-up while low");
   property p_az; $stable(analog_sel)[*4] |-> !(pin_level & analog_sel); endproperty
   a_az: assert property (p_az) else $error("analog read not 0");
   property p_rd;
      ($stable(pad_i) && $stable(analog_sel))[*5] |-> pin_level == (pad_i & ~analog_sel);
   endproperty
   a_rd: assert property (p_rd) else $error("read not pad");
   c_err: cover property (pslverr);
   c_ana: cover property (|analog_sel);
   c_pp: cover property (|(~pad_oe_n & pad_o));
endmodule
bind pio_top pio_top_checker #(.NPINS(NPINS)) i_pio_top_checker (.pclk, .presetn, .psel,
   .penable, .pready, .pslverr, .analog_sel, .pin_level, .pad_i, .pad_o, .pad_oe_n,
   .pad_pullup_en);

// ==== verification/pio_top_tb_top.sv ====
`timescale 1ns/1ps
module pio_top_tb_top;
   import pio_pkg::*;
   localparam int N = 29;
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic         pready, pslverr, err;
   logic         dbg_active = 1'b0, dbg_out = 1'b0, dbg_oe = 1'b0, dbg_in;
   logic [N-1:0] crossbar_skip, analog_sel;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0, prdata, q;
   logic [N-1:0] periph_out = '0, periph_claim = '0, ext_en = '0, ext_v = '0;
   logic [N-1:0] pin_level, pad_i, pad_o, pad_oe_n, pad_pullup_en;
   int           n_mismatch = 0, n_checks = 0;
   always #5 pclk = ~pclk;
   pio_top #(.NPINS(N)) i_pio_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .periph_out, .periph_claim, .dbg_active,
      .dbg_out, .dbg_oe, .dbg_in, .crossbar_skip, .analog_sel,
      .pin_level, .pad_i, .pad_o, .pad_oe_n, .pad_pullup_en);
   pio_pad_model #(.N(N)) i_pio_pad_model (.pad_o, .pad_oe_n, .pad_pullup_en, .ext_en,
      .ext_v, .pclk, .pad_i);
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   // waits 4 edges after release: covers pad update and the 3-edge read path
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_mismatch++;
         final_report();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b1, PIO_ADR_LATCH, 8'h0F);
      chk("oe_noxb", pad_oe_n[7:0], 8'hFF);
      chk("pu_noxb", pad_pullup_en[7:0], 8'hFF);
      $display("reset test done");
      xfer(1'b1, PIO_ADR_CTRL, 8'h01);
      chk("oe_od", pad_oe_n[7:0], 8'h0F);
      chk("pu_od", pad_pullup_en[7:0], 8'h0F);
      xfer(1'b1, PIO_ADR_OUTMODE, 8'hFF);
      chk("oe_pp", pad_oe_n[7:0], 8'h00);
      chk("o_pp", pad_o[7:0], 8'h0F);
      ext_en <= 29'h000FF01;
      ext_v <= 29'h000FF00;
      xfer(1'b1, PIO_ADR_OUTMODE, 8'h00);
      xfer(1'b0, PIO_ADR_LATCH, 8'h00);
      chk("rd_pad", q[7:0], 8'h0E);
      chk("ok_err", {7'h0, err}, 8'h00);
      $display("mode test done");
      xfer(1'b1, PIO_ADR_INMODE + 12'h004, 8'hFF);
      chk("oe_ana", pad_oe_n[15:8], 8'hFF);
      chk("pu_ana", pad_pullup_en[15:8], 8'h00);
      xfer(1'b0, PIO_ADR_LATCH + 12'h004, 8'h00);
      chk("rd_ana", q[7:0], 8'h00);
      xfer(1'b0, 12'h0FC, 8'h00);
      chk("bad_err", {7'h0, err}, 8'h01);
      $display("analog test done");
      periph_claim <= 29'h0010000;
      xfer(1'b1, PIO_ADR_OUTMODE + 12'h008, 8'hFF);
      chk("o_per", pad_o[23:16], 8'hFE);
      xfer(1'b1, PIO_ADR_SKIP + 12'h008, 8'h01);
      chk("o_skip", pad_o[23:16], 8'hFF);
      xfer(1'b1, PIO_ADR_CTRL, 8'h03);
      chk("pu_wpd", pad_pullup_en[7:0], 8'h00);
      $display("crossbar test done");
      // debug owns the shared pin and forces push-pull even with open-drain mode bits
      dbg_active <= 1'b1;
      dbg_oe <= 1'b1;
      ext_en[24] <= 1'b1;
      ext_v[24] <= 1'b0;
      xfer(1'b0, PIO_ADR_SKIP + 12'h008, 8'h00);
      chk("skip_rd", q[7:0], 8'h01);
      chk("skip_out", crossbar_skip[23:16], 8'h01);
      chk("o_dbg_lo", {6'h0, pad_oe_n[24], pad_o[24]}, 8'h00);
      dbg_out <= 1'b1;
      xfer(1'b0, PIO_ADR_INMODE + 12'h004, 8'h00);
      chk("ana_rd", q[7:0], 8'hFF);
      chk("ana_out", analog_sel[15:8], 8'hFF);
      chk("o_dbg_hi", {6'h0, pad_oe_n[24], pad_o[24]}, 8'h01);
      chk("dbg_in_hi", {7'h0, dbg_in}, 8'h01);
      dbg_oe <= 1'b0;
      xfer(1'b0, PIO_ADR_LATCH + 12'h00C, 8'h00);
      chk("dbg_rel", {7'h0, pad_oe_n[24]}, 8'h01);
      chk("dbg_in_lo", {7'h0, dbg_in}, 8'h00);
      chk("lvl_dbg", {7'h0, pin_level[24]}, 8'h00);
      $display("debug test done");
      // a reset in mid-run must bring every cell back to idle with pull-ups on
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      dbg_active <= 1'b0;
      xfer(1'b0, PIO_ADR_CTRL, 8'h00);
      chk("ctrl_rst", q[7:0], 8'h00);
      chk("oe_rst", pad_oe_n[7:0], 8'hFF);
      chk("pu_rst", pad_pullup_en[7:0], 8'hFF);
      $display("second reset test done");
      final_report();
   end
endmodule
